//--- src/zcdl_pkg.sv
// Shared constants and types for the zero-cross detector digital logic.
// Assumes a 40 MHz core clock and an APB slave with 32-bit data.
package zcdl_pkg;

    // APB address width and register indices (byte address is index times four)
    localparam int unsigned ADDR_W       = 8;
    localparam logic [1:0]  IDX_CTRL_A   = 2'h0;   // Control register A
    localparam logic [1:0]  IDX_RSVD     = 2'h1;   // Reserved, reads zero
    localparam logic [1:0]  IDX_EDGE_SEL = 2'h2;   // Interrupt edge select
    localparam logic [1:0]  IDX_STATUS   = 2'h3;   // State and crossing flag

    // Field positions
    localparam int unsigned CTRL_ENABLE_BIT   = 0;
    localparam int unsigned CTRL_INVERT_BIT   = 3;
    localparam int unsigned CTRL_PIN_DRV_BIT  = 6;
    localparam int unsigned CTRL_RUNSTDBY_BIT = 7;
    localparam int unsigned STAT_FLAG_BIT     = 0;
    localparam int unsigned STAT_STATE_BIT    = 4;

    // Values after reset
    localparam logic [7:0] CTRL_A_RESET   = 8'h00;
    localparam logic [1:0] EDGE_SEL_RESET = 2'h0;

    // Start-up interval after enable; output ignored meanwhile
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned STARTUP_NS     = 2000;
    localparam int unsigned STARTUP_CYCLES =
        (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_CNT_W  = 8;

    // Synchroniser depth for the state flag
    localparam int unsigned SYNC_STAGES = 3;

    // Interrupt edge selection
    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } zcdl_edge_t;

    // Start-up sequencer, one-hot
    typedef enum logic [2:0] {
        ST_OFF   = 3'h1,
        ST_START = 3'h2,
        ST_RUN   = 3'h4
    } zcdl_state_t;

    // Control register A contents
    typedef struct packed {
        logic run_stdby;          // Stored only, no sleep logic here
        logic pin_drive_enable;   // Drive detector output on its pin
        logic invert;             // Invert detector output
        logic enable;             // Activate the detector
    } zcdl_ctrl_t;

    // APB request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } zcdl_apb_req_t;

endpackage : zcdl_pkg

//--- src/zcdl_sync3.sv
// Three-stage level synchroniser for the asynchronous detector output.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps
module zcdl_sync3 (
    input  wire logic i_core_clk,   // Core clock
    input  wire logic i_rst,        // Async reset, active high
    input  wire logic i_async,      // Asynchronous level
    output logic      o_sync        // Level after three flops
);
    // Shift chain; stage 0 is read only by stage 1
    logic [zcdl_pkg::SYNC_STAGES-1:0] chain_reg;

    // Plain shift, three edges of latency
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= {chain_reg[zcdl_pkg::SYNC_STAGES-2:0], i_async};
        end
    end

    assign o_sync = chain_reg[zcdl_pkg::SYNC_STAGES-1];
endmodule : zcdl_sync3

//--- src/zcdl_top.sv
// Digital side of the zero-cross detector: control registers over APB,
// polarity, pin drive, level event, state flag and crossing flag.
// Assumes the analog comparator output arrives asynchronously on i_comp_out.
// Operation
// (R01) Software configures pin analog before enabling
// (R02) Pin drive bit routes output to pin
// (R03) Enable bit activates comparator and logic
// (R04) Output invalid during start-up after enable
// (R05) State one above reference, zero below
// (R06) Invert bit reverses output and state
// (R07) Edge selection follows inverted output
// (R08) Event is asynchronous level of output
// (R09) No event inputs accepted
// (R10) Edge select: none, rise, fall, both
// (R11) Flag set on edge, write-one clears
// (R12) State flag lags by three-flop synchroniser
// (R13) Edges from synced output, one-cycle set
`timescale 1ns/1ps
module zcdl_top (
    input  wire logic                    i_core_clk,   // 40 MHz core clock
    input  wire logic                    i_rst,        // Async reset, active high
    input  wire zcdl_pkg::zcdl_apb_req_t i_apb,        // APB request
    output logic [31:0]                  o_prdata,     // APB read data
    output logic                         o_pready,     // APB ready
    output logic                         o_pslverr,    // APB error, unmapped
    input  wire logic                    i_comp_out,   // Raw comparator, async
    output logic                         o_comp_enable,// Comparator power-up
    output logic                         o_out_pin,    // Detector output pin
    output logic                         o_out_pin_oe, // Pin output enable
    output logic                         o_event_level,// Level event to network
    output logic                         o_irq,        // Crossing request
    output logic                         o_zcd_ready   // Start-up interval over
);
    // Registers
    zcdl_pkg::zcdl_ctrl_t  ctrl_reg;       // Control register A
    zcdl_pkg::zcdl_edge_t  edge_sel_reg;   // Interrupt edge select
    zcdl_pkg::zcdl_state_t state_reg;      // Start-up sequencer
    zcdl_pkg::zcdl_state_t state_next;     // Sequencer next state
    logic [zcdl_pkg::STARTUP_CNT_W-1:0] cnt_reg;   // Start-up countdown
    logic                  flag_reg;       // Crossing flag
    logic                  prev_reg;       // Last synced output
    logic [31:0]           prdata_reg;     // Read data, caught in setup
    logic                  pslverr_reg;    // Error, caught in setup

    // Decoded wires
    logic        out_level;      // Polarity-adjusted detector output
    logic        state_sync;     // Synchronised output for state flag
    logic        rise;           // Rising edge of synced output
    logic        fall;           // Falling edge of synced output
    logic        set_flag;       // One-cycle flag set
    logic        setup_ph;       // APB setup cycle
    logic        wr_en;          // APB write takes effect
    logic [1:0]  idx;            // Register index
    logic        addr_ok;        // Address maps to a register
    logic        wr_ctrl;        // Write to control A
    logic        wr_edge;        // Write to edge select
    logic        wr_stat;        // Write to status
    logic [31:0] rd_word;        // Read mux output
    logic [zcdl_pkg::STARTUP_CNT_W-1:0] startup_cnt;  // Load value

    // Edge qualifier, used by the flag logic only
    function automatic logic edge_hit(input zcdl_pkg::zcdl_edge_t mode,
                                      input logic r, input logic f);
        edge_hit = ((mode == zcdl_pkg::EDGE_RISE) && r) ||   // R10
                   ((mode == zcdl_pkg::EDGE_FALL) && f) ||
                   ((mode == zcdl_pkg::EDGE_BOTH) && (r || f));
    endfunction : edge_hit

    // Comparator runs only while enabled; output held low otherwise
    assign o_comp_enable = ctrl_reg.enable;                          // R03
    assign out_level     = ctrl_reg.enable & (i_comp_out ^ ctrl_reg.invert); // R05 R06
    // Asynchronous level straight from the comparator path, no clocking
    assign o_event_level = out_level;                                // R08
    // Module has no event input port at all                             R09
    assign o_out_pin     = out_level;
    assign o_out_pin_oe  = ctrl_reg.enable & ctrl_reg.pin_drive_enable; // R02

    // Synchroniser on the already inverted output, so inversion hits edges too
    zcdl_sync3 u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    (out_level),   // R07
        .o_sync     (state_sync)   // R12
    );

    // Edges from the synced level; ignored until start-up has elapsed
    assign rise     = state_sync & ~prev_reg;                            // R13
    assign fall     = ~state_sync & prev_reg;                            // R13
    assign set_flag = (state_reg == zcdl_pkg::ST_RUN) &&
                      edge_hit(edge_sel_reg, rise, fall);                // R04 R13
    assign o_irq       = flag_reg && (edge_sel_reg != zcdl_pkg::EDGE_NONE); // R11
    assign o_zcd_ready = (state_reg == zcdl_pkg::ST_RUN);                // R04

    // APB decode; zero-wait slave, data prepared in the setup cycle
    assign setup_ph = i_apb.psel & ~i_apb.penable;
    assign wr_en    = i_apb.psel & i_apb.penable & i_apb.pwrite;
    assign idx      = i_apb.paddr[3:2];
    assign addr_ok  = (i_apb.paddr[1:0] == 2'h0) &&
                      (i_apb.paddr[zcdl_pkg::ADDR_W-1:4] == '0);
    assign wr_ctrl  = wr_en && addr_ok && (idx == zcdl_pkg::IDX_CTRL_A);
    assign wr_edge  = wr_en && addr_ok && (idx == zcdl_pkg::IDX_EDGE_SEL);
    assign wr_stat  = wr_en && addr_ok && (idx == zcdl_pkg::IDX_STATUS);
    assign o_pready  = 1'b1;
    assign o_prdata  = prdata_reg;
    assign o_pslverr = pslverr_reg;
    assign startup_cnt = zcdl_pkg::STARTUP_CNT_W'(zcdl_pkg::STARTUP_CYCLES - 1);

    // Read mux; reserved word and bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (addr_ok) begin
            case (idx)
                zcdl_pkg::IDX_CTRL_A: begin
                    rd_word[zcdl_pkg::CTRL_ENABLE_BIT]   = ctrl_reg.enable;
                    rd_word[zcdl_pkg::CTRL_INVERT_BIT]   = ctrl_reg.invert;
                    rd_word[zcdl_pkg::CTRL_PIN_DRV_BIT]  = ctrl_reg.pin_drive_enable;
                    rd_word[zcdl_pkg::CTRL_RUNSTDBY_BIT] = ctrl_reg.run_stdby;
                end
                zcdl_pkg::IDX_EDGE_SEL: begin
                    rd_word[1:0] = edge_sel_reg;
                end
                zcdl_pkg::IDX_STATUS: begin
                    rd_word[zcdl_pkg::STAT_FLAG_BIT]  = flag_reg;
                    rd_word[zcdl_pkg::STAT_STATE_BIT] = state_sync;  // R12
                end
                default: begin
                    rd_word = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data and error caught in setup, stable through access
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg  <= rd_word;
            pslverr_reg <= ~addr_ok;
        end
    end

    // Software-written registers; unmapped writes dropped
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg     <= zcdl_pkg::zcdl_ctrl_t'({zcdl_pkg::CTRL_A_RESET[7],
                            zcdl_pkg::CTRL_A_RESET[6], zcdl_pkg::CTRL_A_RESET[3],
                            zcdl_pkg::CTRL_A_RESET[0]});
            edge_sel_reg <= zcdl_pkg::zcdl_edge_t'(zcdl_pkg::EDGE_SEL_RESET);
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.enable           <= i_apb.pwdata[zcdl_pkg::CTRL_ENABLE_BIT];  // R03
                ctrl_reg.invert           <= i_apb.pwdata[zcdl_pkg::CTRL_INVERT_BIT];  // R06
                ctrl_reg.pin_drive_enable <= i_apb.pwdata[zcdl_pkg::CTRL_PIN_DRV_BIT]; // R02
                ctrl_reg.run_stdby        <= i_apb.pwdata[zcdl_pkg::CTRL_RUNSTDBY_BIT];
            end
            if (wr_edge) begin
                edge_sel_reg <= zcdl_pkg::zcdl_edge_t'(i_apb.pwdata[1:0]); // R10
            end
        end
    end

    // Crossing flag: a set in the clearing cycle wins
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            flag_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= state_sync;
            if (set_flag) begin
                flag_reg <= 1'b1;                                  // R11
            end else if (wr_stat && i_apb.pwdata[zcdl_pkg::STAT_FLAG_BIT]) begin
                flag_reg <= 1'b0;                                  // R11
            end
        end
    end

    // Start-up sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            zcdl_pkg::ST_OFF: begin
                if (ctrl_reg.enable) state_next = zcdl_pkg::ST_START;
            end
            zcdl_pkg::ST_START: begin
                if (!ctrl_reg.enable)  state_next = zcdl_pkg::ST_OFF;
                else if (cnt_reg == '0) state_next = zcdl_pkg::ST_RUN;  // R04
            end
            zcdl_pkg::ST_RUN: begin
                if (!ctrl_reg.enable) state_next = zcdl_pkg::ST_OFF;
            end
            default: begin
                state_next = zcdl_pkg::ST_OFF;
            end
        endcase
    end

    // Sequencer and countdown; count reloads while off
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= zcdl_pkg::ST_OFF;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg != zcdl_pkg::ST_START) cnt_reg <= startup_cnt;
            else if (cnt_reg != '0)              cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    pin_drive_a: assert property (wr_ctrl && i_apb.pwdata[0] && i_apb.pwdata[6]
        |=> o_out_pin_oe && (o_out_pin == out_level)) // R02
        else $error("pin not driven after enable write");
    comp_off_a: assert property (!ctrl_reg.enable
        |-> !o_comp_enable && !o_event_level && !o_out_pin_oe) // R03
        else $error("detector active while disabled");
    startup_a: assert property ($rose(ctrl_reg.enable)
        |-> !o_zcd_ready [*8]) // R04
        else $error("ready too early after enable");
    state_hi_a: assert property ((ctrl_reg.enable && !ctrl_reg.invert && i_comp_out) [*4]
        |-> state_sync) // R05
        else $error("state not high above reference");
    state_inv_a: assert property ((ctrl_reg.enable && ctrl_reg.invert && i_comp_out) [*4]
        |-> !state_sync) // R06
        else $error("state not inverted");
    event_lvl_a: assert property (ctrl_reg.enable
        |-> o_event_level == (i_comp_out ^ ctrl_reg.invert)) // R08
        else $error("event level mismatch");
    sync_lag_a: assert property (##3 state_sync == $past(out_level, 3)) // R12
        else $error("state lag not three cycles");
    rise_set_a: assert property (o_zcd_ready && edge_sel_reg == zcdl_pkg::EDGE_RISE
        && rise |=> flag_reg) // R07 R10
        else $error("rising edge did not set flag");
    none_mode_a: assert property (edge_sel_reg == zcdl_pkg::EDGE_NONE && !flag_reg
        |=> !flag_reg) // R10
        else $error("flag set with edges disabled");
    clear_a: assert property (wr_stat && i_apb.pwdata[0] && !set_flag
        |=> !flag_reg && !o_irq) // R11
        else $error("write one did not clear flag");
    // A write to the edge select may legally drop the request to none
    hold_irq_a: assert property (flag_reg && !wr_stat && !wr_edge
        && edge_sel_reg != zcdl_pkg::EDGE_NONE |=> o_irq) // R11
        else $error("request dropped while flag set");
    one_set_a: assert property (set_flag |=> !set_flag) // R13
        else $error("edge set flag for two cycles");

    rise_c: cover property (o_zcd_ready ##1 set_flag && rise);
    fall_c: cover property (o_zcd_ready ##1 set_flag && fall);
    clear_c: cover property (flag_reg ##1 wr_stat ##1 !flag_reg);
    err_c: cover property (i_apb.psel && i_apb.penable && o_pslverr);
endmodule : zcdl_top

//--- dv/zcdl_ac_source.sv
// Behavioural model of the AC source seen through the series resistor.
// Assumes the sensing pin is already analog with its buffer and pulls off.
`timescale 1ns/1ps
module zcdl_ac_source (
    input  wire logic i_slow,   // Long settle before a crossing lands
    output logic      o_comp    // Comparator level, 1 = above reference
);
    // Pin set up as analog before the bench enables the unit
    initial begin
        o_comp = 1'b0;
    end

    // Crossings land off the clock edge, as a real mains crossing would
    task automatic set_level(input logic l);
        #(i_slow ? 61 : 7);
        o_comp = l;
    endtask : set_level
endmodule : zcdl_ac_source

//--- dv/tb_zero_cross_detector_logic.sv
// Self-checking bench for the zero-cross detector logic over APB.
// Assumes the AC source model in zcdl_ac_source and a 40 MHz core clock.
`timescale 1ns/1ps
module tb_zero_cross_detector_logic;
    typedef struct packed {
        logic [31:0] d;    // Expected read data
        logic        e;    // Expected error
        logic        rd;   // Read, so data is compared
    } zcdl_note_t;

    localparam logic [7:0]  A_CTRL = {4'h0, zcdl_pkg::IDX_CTRL_A, 2'h0};   // Control word
    localparam logic [7:0]  A_RSVD = {4'h0, zcdl_pkg::IDX_RSVD, 2'h0};     // Reserved word
    localparam logic [7:0]  A_EDGE = {4'h0, zcdl_pkg::IDX_EDGE_SEL, 2'h0}; // Edge select
    localparam logic [7:0]  A_STAT = {4'h0, zcdl_pkg::IDX_STATUS, 2'h0};   // Status word
    localparam logic [31:0] B_EN   = 32'h1 << zcdl_pkg::CTRL_ENABLE_BIT;   // Enable bit
    localparam logic [31:0] B_INV  = 32'h1 << zcdl_pkg::CTRL_INVERT_BIT;   // Invert bit
    localparam logic [31:0] B_PIN  = 32'h1 << zcdl_pkg::CTRL_PIN_DRV_BIT;  // Pin drive bit
    localparam logic [31:0] B_SBY  = 32'h1 << zcdl_pkg::CTRL_RUNSTDBY_BIT; // Stored-only bit
    localparam logic [31:0] B_FLAG = 32'h1 << zcdl_pkg::STAT_FLAG_BIT;     // Crossing flag
    localparam logic [31:0] B_ST   = 32'h1 << zcdl_pkg::STAT_STATE_BIT;    // State bit

    logic                    i_core_clk = 1'b0; // Core clock
    logic                    i_rst      = 1'b1; // Reset, active high
    zcdl_pkg::zcdl_apb_req_t req        = '0;   // APB request
    logic [31:0]             o_prdata;          // Read data
    logic                    o_pready;          // Ready
    logic                    o_pslverr;         // Error
    logic                    comp;              // Comparator from source
    logic                    o_comp_enable;     // Comparator power
    logic                    o_out_pin;         // Output pin
    logic                    o_out_pin_oe;      // Pin enable
    logic                    o_event_level;     // Level event
    logic                    o_irq;             // Crossing request
    logic                    o_zcd_ready;       // Start-up over
    logic                    slow       = 1'b0; // Source speed
    integer                  seed       = 32'h63292c01;
    int                      mismatches = 0;
    int                      checks     = 0;
    zcdl_note_t              notes[$];          // Expected bus results
    zcdl_note_t              nt;                // Note being compared
    logic [31:0]             wd;                // Control word in use
    logic [1:0]              mm;                // Edge mode in loop
    int                      n;                 // Wait counter

    // 40 MHz clock
    always #12.5 i_core_clk = ~i_core_clk;

    zcdl_top u_dut (
        .i_core_clk    (i_core_clk),
        .i_rst         (i_rst),
        .i_apb         (req),
        .o_prdata      (o_prdata),
        .o_pready      (o_pready),
        .o_pslverr     (o_pslverr),
        .i_comp_out    (comp),
        .o_comp_enable (o_comp_enable),
        .o_out_pin     (o_out_pin),
        .o_out_pin_oe  (o_out_pin_oe),
        .o_event_level (o_event_level),
        .o_irq         (o_irq),
        .o_zcd_ready   (o_zcd_ready)
    );

    zcdl_ac_source u_src (
        .i_slow (slow),
        .o_comp (comp)
    );

    // Compare one value and count it
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // One APB transfer; the expectation is noted before it starts
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic er);
        int k;
        k = 0;
        notes.push_back('{d: ex, e: er, rd: !wr});
        @(posedge i_core_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_core_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            mismatches++;
            finish_test();
        end
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        // Let registers launched at this edge settle before the caller looks
        #1;
    endtask : apb

    // Move the source and give the synchroniser time to settle
    task automatic lvl(input logic l);
        u_src.set_level(l);
        repeat (6) @(posedge i_core_clk);
    endtask : lvl

    // Monitor: every completed transfer takes the oldest note
    always @(posedge i_core_clk) begin
        if (req.psel && req.penable && o_pready === 1'b1) begin
            nt = notes.pop_front();
            chk("pslverr", 32'(nt.e), 32'(o_pslverr));
            if (nt.rd) begin
                chk("prdata", nt.d, o_prdata);
            end
        end
    end

    // Single exit point for pass, fail and timeout
    task automatic finish_test();
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Watchdog well past the expected few hundred cycles
    initial begin
        #(25 * 20000);
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        // Reset values, reserved word and unmapped places
        apb(1'b0, A_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, A_EDGE, 32'h0, 32'h0, 1'b0);
        apb(1'b0, A_STAT, 32'h0, 32'h0, 1'b0);
        apb(1'b1, A_RSVD, $random(seed), 32'h0, 1'b0);
        apb(1'b0, A_RSVD, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 8'h10, $random(seed), 32'h0, 1'b1);
        apb(1'b0, 8'h02, 32'h0, 32'h0, 1'b1);
        apb(1'b0, A_CTRL, 32'h0, 32'h0, 1'b0);
        chk("comp_enable", 32'h0, 32'(o_comp_enable));
        // Enable with pin drive; stored-only bit chosen at random
        wd = B_EN | B_PIN | ($random(seed) & B_SBY);
        apb(1'b1, A_CTRL, wd, 32'h0, 1'b0);
        apb(1'b0, A_CTRL, 32'h0, wd, 1'b0);
        chk("comp_enable", 32'h1, 32'(o_comp_enable));
        chk("pin_oe", 32'h1, 32'(o_out_pin_oe));
        // Nothing is trusted until start-up has passed
        n = 0;
        while (o_zcd_ready !== 1'b1 && n < 300) begin
            @(posedge i_core_clk);
            n++;
        end
        chk("zcd_ready", 32'h1, 32'(o_zcd_ready));
        // Rising crossing: request four edges after the change
        apb(1'b1, A_EDGE, 32'(zcdl_pkg::EDGE_RISE), 32'h0, 1'b0);
        @(posedge i_core_clk);
        u_src.set_level(1'b1);
        n = 0;
        while (o_irq !== 1'b1 && n < 20) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        chk("irq_lag", 32'h4, 32'(n));
        chk("out_pin", 32'h1, 32'(o_out_pin));
        chk("event", 32'h1, 32'(o_event_level));
        apb(1'b0, A_STAT, 32'h0, B_ST | B_FLAG, 1'b0);
        // Every edge mode, falling then rising
        for (int m = 0; m < 4; m++) begin
            mm = m[1:0];
            apb(1'b1, A_EDGE, 32'(mm), 32'h0, 1'b0);
            apb(1'b0, A_EDGE, 32'h0, 32'(mm), 1'b0);
            apb(1'b1, A_STAT, B_FLAG, 32'h0, 1'b0);
            lvl(1'b0);
            chk("irq_fall", 32'(mm[1]), 32'(o_irq));
            if (mm != 2'h0) begin
                apb(1'b1, A_STAT, 32'h0, 32'h0, 1'b0);
                apb(1'b0, A_STAT, 32'h0, mm[1] ? B_FLAG : 32'h0, 1'b0);
                apb(1'b1, A_STAT, B_FLAG, 32'h0, 1'b0);
            end
            lvl(1'b1);
            chk("irq_rise", 32'(mm[0]), 32'(o_irq));
            if (mm != 2'h0) begin
                apb(1'b0, A_STAT, 32'h0, B_ST | (mm[0] ? B_FLAG : 32'h0), 1'b0);
            end
        end
        // Inverted output: rising mode now fires on a falling input
        apb(1'b1, A_EDGE, 32'(zcdl_pkg::EDGE_RISE), 32'h0, 1'b0);
        apb(1'b1, A_STAT, B_FLAG, 32'h0, 1'b0);
        apb(1'b1, A_CTRL, wd | B_INV, 32'h0, 1'b0);
        repeat (6) @(posedge i_core_clk);
        chk("out_pin_inv", 32'h0, 32'(o_out_pin));
        chk("event_inv", 32'h0, 32'(o_event_level));
        apb(1'b0, A_STAT, 32'h0, 32'h0, 1'b0);
        slow = 1'b1;
        lvl(1'b0);
        chk("irq_inv", 32'h1, 32'(o_irq));
        chk("out_pin_inv", 32'h1, 32'(o_out_pin));
        apb(1'b0, A_STAT, 32'h0, B_ST | B_FLAG, 1'b0);
        apb(1'b1, A_STAT, B_FLAG, 32'h0, 1'b0);
        chk("irq_clr", 32'h0, 32'(o_irq));
        // Pin drive off, then disable
        apb(1'b1, A_CTRL, B_EN, 32'h0, 1'b0);
        chk("pin_oe", 32'h0, 32'(o_out_pin_oe));
        apb(1'b1, A_CTRL, 32'h0, 32'h0, 1'b0);
        chk("comp_enable", 32'h0, 32'(o_comp_enable));
        chk("out_pin", 32'h0, 32'(o_out_pin));
        // Sequencer leaves the run state one edge after the enable drops
        repeat (2) @(posedge i_core_clk);
        chk("zcd_ready", 32'h0, 32'(o_zcd_ready));
        finish_test();
    end
endmodule : tb_zero_cross_detector_logic
